// ---- rtl/pa_port_a.sv ----
// port a: direction and data registers, pin muxing, ahb-lite slave
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module pa_port_a
  import pa_pkg::*;
(
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // operating mode strap and standby
  input wire logic [2:0] op_mode,
  input wire logic hw_standby,
  // timer channel 2
  input wire logic ch2_b_ctrl_top,
  input wire logic ch2_b_ctrl_mid,
  input wire logic ch2_b_ctrl_low,
  input wire logic ch2_pulse_width_mode,
  input wire logic ch2_b_compare_out,
  output logic ch2_capture_compare_b,
  // timing pattern unit
  input wire logic [7:0] pattern_enable_reg_a,
  input wire logic [7:0] pattern_out_data,
  // address output
  input wire logic address_out_bit_20,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  // ----------------------------------------------------------------
  // pin and strap synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [2:0] mode_s1_r;
  logic [2:0] mode_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
    end else if (ce) begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      mode_s1_r <= op_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // mode capture after reset release
  // ----------------------------------------------------------------
  // strap needs two edges through the synchroniser before it is trusted
  logic [1:0] init_cnt_r;
  logic init_done;
  logic [2:0] mode_r;
  logic addr_mode;

  assign init_done = (init_cnt_r == 2'h3);
  assign addr_mode = pa_addr_mode(mode_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_r <= 2'h0;
    end else if (ce && !init_done) begin
      init_cnt_r <= init_cnt_r + 2'h1;
    end
  end

  // mode is latched once; a strap change later has no effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= 3'h0;
    end else if (ce && (init_cnt_r == 2'h2)) begin
      mode_r <= mode_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  logic acc_start;
  logic wr_pend_r;
  logic wr_dir_r;
  logic wr_data_r;

  assign acc_start = hsel && hready && (htrans == PA_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_dir_r <= 1'b0;
      wr_data_r <= 1'b0;
    end else if (ce && hready) begin
      wr_pend_r <= acc_start && hwrite;
      wr_dir_r <= acc_start && hwrite && (haddr == PA_DIR_ADDR);
      wr_data_r <= acc_start && hwrite && (haddr == PA_DATA_ADDR);
    end
  end

  // zero wait states, only okay answers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // direction and data registers
  // ----------------------------------------------------------------
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;

  always_comb begin
    dir_nxt = dir_r;
    data_nxt = data_r;
    if (hw_standby || (init_cnt_r == 2'h2)) begin
      // reset value depends on the strap, so it lands on the same edge as the mode capture
      dir_nxt = pa_addr_mode(init_done ? mode_r : mode_s2_r) ? PA_DIR_RST_ADDR : PA_DIR_RST;
      data_nxt = PA_DATA_RST;
    end else begin
      if (wr_dir_r) begin
        dir_nxt = pa_dir_fix(hwdata[7:0], mode_r);
      end
      if (wr_data_r) begin
        data_nxt = hwdata[7:0];
      end
    end
  end

  // no software standby input: registers simply hold, pins keep driving
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= PA_DIR_RST;
      data_r <= PA_DATA_RST;
    end else if (ce) begin
      dir_r <= dir_nxt;
      data_r <= data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // next values forward a write still in its data phase
  logic [7:0] dir_eff;
  logic [7:0] port_read;

  assign dir_eff = pa_dir_fix(dir_r, mode_r);
  assign port_read = (pa_dir_fix(dir_nxt, mode_r) & data_nxt) | (~pa_dir_fix(dir_nxt, mode_r) & pin_s2_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && hready) begin
      hrdata <= 32'h0000_0000;
      if (acc_start && !hwrite && (haddr == PA_DIR_ADDR)) begin
        hrdata <= {24'h00_0000, PA_DIR_READ};
      end else if (acc_start && !hwrite && (haddr == PA_DATA_ADDR)) begin
        hrdata <= {24'h00_0000, port_read};
      end
    end
  end

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  logic b_compare;
  logic top_is_input;

  assign b_compare = pa_b_compare({ch2_b_ctrl_top, ch2_b_ctrl_mid, ch2_b_ctrl_low});
  assign top_is_input = init_done && !addr_mode && !b_compare && !dir_eff[PA_TOP_BIT];

  always_comb begin
    // pattern only reaches pins whose direction bit is set
    pin_oe = dir_eff;
    for (int i = 0; i < 8; i++) begin
      pin_out[i] = pattern_enable_reg_a[i] ? pattern_out_data[i] : data_r[i];
    end
    if (!init_done) begin
      pin_oe = 8'h00;
      pin_out = 8'h00;
    end else if (addr_mode) begin
      pin_oe[PA_TOP_BIT] = 1'b1;
      pin_out[PA_TOP_BIT] = address_out_bit_20;
    end else if (b_compare) begin
      pin_oe[PA_TOP_BIT] = 1'b1;
      pin_out[PA_TOP_BIT] = ch2_b_compare_out;
    end
  end

  // capture input sees the synchronised pin level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch2_capture_compare_b <= 1'b0;
    end else if (ce) begin
      ch2_capture_compare_b <= top_is_input && ch2_b_ctrl_top && !ch2_pulse_width_mode && pin_s2_r[PA_TOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dir_read_ones: assert property (
    (ce && acc_start && !hwrite && haddr == PA_DIR_ADDR) |=> (hrdata == 32'h0000_00ff))
    else $error("direction read did not return all ones");

  a_data_read_mix: assert property (
    (ce && acc_start && !hwrite && haddr == PA_DATA_ADDR && !wr_pend_r)
    |=> (hrdata[7:0] == (($past(dir_eff) & $past(data_r)) | (~$past(dir_eff) & $past(pin_s2_r)))))
    else $error("data read mixes stored bits and pins wrongly");

  a_data_write: assert property (
    (ce && wr_data_r && !hw_standby && init_done) |=> (data_r == $past(hwdata[7:0])))
    else $error("data write not stored");

  a_standby_clear: assert property (
    (ce && hw_standby) |=> (data_r == 8'h00) && (dir_r[6:0] == 7'h00))
    else $error("hardware standby did not clear registers");

  a_top_addr_pin: assert property (
    (init_done && addr_mode) |-> pin_oe[7] && (pin_out[7] == address_out_bit_20) && dir_eff[7])
    else $error("top pin not driving address bit 20");

  a_dir_top_hold: assert property (
    (ce && init_done && addr_mode && wr_dir_r) |=> dir_r[7])
    else $error("top direction bit cleared in address mode");

  a_compare_out: assert property (
    (init_done && !addr_mode && b_compare) |-> pin_oe[7] && (pin_out[7] == ch2_b_compare_out))
    else $error("compare output not on top pin");

  a_low_pin_dir: assert property (
    init_done |-> (pin_oe[6:0] == dir_r[6:0]))
    else $error("low pin enables differ from direction");

  a_capture_feed: assert property (
    (ce && ch2_pulse_width_mode) |=> !ch2_capture_compare_b)
    else $error("capture fed while pulse width mode on");

  // ----------------------------------------------------------------
  // reset, hold and pin selection checks
  // ----------------------------------------------------------------

  a_reset_dir_low: assert property (
    (ce && init_cnt_r == 2'h2 && !hw_standby && !pa_addr_mode(mode_s2_r))
    |=> (dir_r == PA_DIR_RST))
    else $error("direction not cleared after reset");

  a_reset_dir_addr: assert property (
    (ce && init_cnt_r == 2'h2 && pa_addr_mode(mode_s2_r))
    |=> (dir_r == PA_DIR_RST_ADDR))
    else $error("direction not set to address value after reset");

  a_standby_dir: assert property (
    (ce && hw_standby && init_done)
    |=> (dir_r == (addr_mode ? PA_DIR_RST_ADDR : PA_DIR_RST)))
    else $error("hardware standby loaded wrong direction");

  a_pins_idle_init: assert property (
    !init_done
    |-> (pin_oe == 8'h00))
    else $error("pins driven before mode capture");

  a_dir_hold: assert property (
    (ce && init_done && !hw_standby && !wr_dir_r)
    |=> $stable(dir_r))
    else $error("direction changed without a write");

  a_data_hold: assert property (
    (ce && init_done && !hw_standby && !wr_data_r)
    |=> $stable(data_r))
    else $error("data changed without a write");

  a_ce_freeze: assert property (
    !ce
    |=> $stable(dir_r) && $stable(data_r) && $stable(hrdata))
    else $error("state moved while clock enable low");

  a_top_port_out: assert property (
    (init_done && !addr_mode && !b_compare && dir_r[7] && !pattern_enable_reg_a[7])
    |-> pin_oe[7] && (pin_out[7] == data_r[7]))
    else $error("top pin not driving stored data");

  a_top_pattern: assert property (
    (init_done && !addr_mode && !b_compare && dir_r[7] && pattern_enable_reg_a[7])
    |-> pin_oe[7] && (pin_out[7] == pattern_out_data[7]))
    else $error("top pin not driving pattern value");

  a_top_input: assert property (
    (init_done && !addr_mode && !b_compare && !dir_r[7])
    |-> !pin_oe[7])
    else $error("top pin driven while input");

  a_low_pin_out: assert property (
    (init_done && pattern_enable_reg_a[6:0] == 7'h00)
    |-> (pin_out[6:0] == data_r[6:0]))
    else $error("low pins not driving stored data");

  a_capture_pass: assert property (
    (ce && top_is_input && ch2_b_ctrl_top && !ch2_pulse_width_mode)
    |=> (ch2_capture_compare_b == $past(pin_s2_r[PA_TOP_BIT])))
    else $error("capture input does not follow top pin");

  a_capture_off: assert property (
    (ce && !ch2_b_ctrl_top)
    |=> !ch2_capture_compare_b)
    else $error("capture fed while control top bit clear");

  a_b_top_set: assert property (
    (init_done && !addr_mode && ch2_b_ctrl_top)
    |-> (pin_oe[7] == dir_r[7]))
    else $error("compare output taken with control top bit set");

  a_read_upper: assert property (
    (ce && acc_start)
    |=> (hrdata[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");

  a_dir_write: assert property (
    (ce && wr_dir_r && !hw_standby && init_done)
    |=> (dir_r == pa_dir_fix($past(hwdata[7:0]), mode_r)))
    else $error("direction write not stored");

  a_top_dir_follow: assert property (
    (init_done && !addr_mode && !b_compare)
    |-> (pin_oe[7] == dir_r[7]))
    else $error("top pin enable differs from direction");

endmodule

// ---- rtl/pa_pkg.sv ----
// constants, register map and decode helpers for the 8-bit port a block
// Function
// - the port has eight pins, each set as input or output on its own.
// - after reset or hardware standby every pin is an input, apart from the address pin in modes 3 and 4.
// - in modes 3 and 4 the top pin always drives address bit 20, whatever software writes.
// - a direction bit of 1 makes its pin an output and 0 makes it an input.
// - the direction register is write-only and reads back as all ones.
// - the direction register resets to 00 in modes 1, 2, 5, 6 and 7 and to 80 in modes 3 and 4.
// - software standby keeps the direction register, so outputs keep driving.
// - a general output pin drives its stored data bit.
// - a data read gives the stored bit where direction is 1 and the pin level where it is 0.
// - the data register clears to 00 on reset and hardware standby and holds in software standby.
// - pins not claimed by another unit work as plain general input/output.
// - in modes 1, 2, 6 and 7 a channel 2 b compare setting makes the top pin drive the compare output.
// - otherwise the top pin is input at direction 0, port output at 1 with pattern off, pattern output with it on.
// - the b compare setting applies for field 001 or 01x; 000 or top bit set leaves port or pattern use.
// - the top pin as port input feeds the channel 2 b capture input when control top is 1 and pulse width is off.
package pa_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [23:0] PA_DIR_IDX = 24'hee009;
  localparam logic [23:0] PA_DATA_IDX = 24'hfffd9;
  localparam logic [31:0] PA_DIR_ADDR = {6'h00, PA_DIR_IDX, 2'h0};
  localparam logic [31:0] PA_DATA_ADDR = {6'h00, PA_DATA_IDX, 2'h0};

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] PA_DIR_RST = 8'h00;
  localparam logic [7:0] PA_DIR_RST_ADDR = 8'h80;
  localparam logic [7:0] PA_DATA_RST = 8'h00;
  localparam logic [7:0] PA_DIR_READ = 8'hff;
  localparam logic [7:0] PA_TOP_MASK = 8'h80;
  localparam int PA_TOP_BIT = 7;
  localparam logic [2:0] PA_MODE_3 = 3'h3;
  localparam logic [2:0] PA_MODE_4 = 3'h4;
  localparam logic [1:0] PA_HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic pa_addr_mode(input logic [2:0] mode);
    pa_addr_mode = (mode == PA_MODE_3) || (mode == PA_MODE_4);
  endfunction

  // compare on b for field 001 or 01x
  function automatic logic pa_b_compare(input logic [2:0] ctrl);
    pa_b_compare = !ctrl[2] && (ctrl[1:0] != 2'h0);
  endfunction

  // direction value that mode allows to be stored
  function automatic logic [7:0] pa_dir_fix(input logic [7:0] v, input logic [2:0] mode);
    pa_dir_fix = pa_addr_mode(mode) ? (v | PA_TOP_MASK) : v;
  endfunction

endpackage

// ---- tb/pa_pins_model.sv ----
// far-side model of the port a pins: wire level seen by the block
`timescale 1ns/1ps
module pa_pins_model (
  // design side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // outside drivers
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // a driven pin reads back its own level, an undriven one follows the outside driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the port a block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import pa_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, op_mode, ctrl;
  logic hw_standby, pwm, cmp_out, a20, capture;
  logic [7:0] pat_en, pat_data, ext, pin_in, pin_out, pin_oe;
  int num_errors = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] dir, data, ext, rd;} pa_row_s;
  pa_row_s rows[4] = '{'{8'hff, 8'ha5, 8'h00, 8'ha5}, '{8'h00, 8'h5a, 8'hc3, 8'hc3},
                       '{8'h0f, 8'h3c, 8'ha0, 8'hac}, '{8'hf0, 8'h96, 8'h05, 8'h95}};

  assign hready = hreadyout;
  pa_port_a dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .op_mode(op_mode), .hw_standby(hw_standby),
    .ch2_b_ctrl_top(ctrl[2]), .ch2_b_ctrl_mid(ctrl[1]), .ch2_b_ctrl_low(ctrl[0]),
    .ch2_pulse_width_mode(pwm), .ch2_b_compare_out(cmp_out), .ch2_capture_compare_b(capture),
    .pattern_enable_reg_a(pat_en), .pattern_out_data(pat_data), .address_out_bit_20(a20),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pa_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // bus and timing helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PA_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // mode strap is held steady across release so the init counter latches it
  task automatic do_reset(input logic [2:0] m);
    op_mode <= m;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    tick(4);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results();
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hw_standby, pwm, cmp_out, a20, ctrl, pat_en, pat_data, ext} = '0;
    hsize = 3'h2;
    ce = 1'b1;
    hresetn = 1'b0;
    op_mode = 3'h1;
    do_reset(3'h1);
    `CHK(pin_oe, PA_DIR_RST)
    bus(1'b0, PA_DIR_ADDR, 32'h0);
    `CHK(rd[7:0], PA_DIR_READ)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    bus(1'b1, PA_DIR_ADDR, 32'hff);
    bus(1'b0, PA_DATA_ADDR, 32'h0);
    `CHK(rd[7:0], PA_DATA_RST)
    $display("reset test done");
    foreach (rows[i]) begin
      ext <= rows[i].ext;
      bus(1'b1, PA_DIR_ADDR, {24'h0, rows[i].dir});
      bus(1'b1, PA_DATA_ADDR, {24'h0, rows[i].data});
      tick(3);
      `CHK(pin_oe, rows[i].dir)
      `CHK(pin_out & pin_oe, rows[i].data & rows[i].dir)
      bus(1'b0, PA_DATA_ADDR, 32'h0);
      `CHK(rd[7:0], rows[i].rd)
    end
    $display("table test done");
    bus(1'b1, 32'h0000_0100, 32'hff);
    bus(1'b0, 32'h0000_0100, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pin_oe, 8'hf0)
    $display("unmapped test done");
    bus(1'b1, PA_DIR_ADDR, 32'h0);
    cmp_out <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      ctrl <= c[2:0];
      tick(1);
      `CHK(pin_oe[7], (c >= 1 && c <= 3))
      `CHK(pin_out[7] & pin_oe[7], (c >= 1 && c <= 3))
    end
    ctrl <= 3'h0;
    pat_en <= 8'h80;
    pat_data <= 8'h80;
    bus(1'b1, PA_DIR_ADDR, 32'h80);
    bus(1'b1, PA_DATA_ADDR, 32'h00);
    tick(1);
    `CHK({pin_oe[7], pin_out[7]}, 2'h3)
    bus(1'b0, PA_DATA_ADDR, 32'h0);
    `CHK(rd[7], 1'b0)
    pat_en <= 8'h00;
    tick(1);
    `CHK({pin_oe[7], pin_out[7]}, 2'h2)
    $display("top pin test done");
    bus(1'b1, PA_DIR_ADDR, 32'h0);
    ctrl <= 3'h4;
    ext <= 8'h80;
    tick(4);
    `CHK(capture, 1'b1)
    pwm <= 1'b1;
    tick(4);
    `CHK(capture, 1'b0)
    pwm <= 1'b0;
    ctrl <= 3'h0;
    tick(4);
    `CHK(capture, 1'b0)
    $display("capture test done");
    bus(1'b1, PA_DIR_ADDR, 32'hff);
    bus(1'b1, PA_DATA_ADDR, 32'h55);
    tick(20);
    `CHK(pin_out & pin_oe, 8'h55)
    hw_standby <= 1'b1;
    tick(2);
    `CHK(pin_oe, PA_DIR_RST)
    hw_standby <= 1'b0;
    bus(1'b1, PA_DIR_ADDR, 32'hff);
    bus(1'b0, PA_DATA_ADDR, 32'h0);
    `CHK(rd[7:0], PA_DATA_RST)
    $display("standby test done");
    ce <= 1'b0;
    bus(1'b1, PA_DATA_ADDR, 32'hff);
    ce <= 1'b1;
    bus(1'b0, PA_DATA_ADDR, 32'h0);
    `CHK(rd[7:0], PA_DATA_RST)
    $display("clock enable test done");
    do_reset(3'h3);
    `CHK(pin_oe, PA_DIR_RST_ADDR)
    bus(1'b1, PA_DIR_ADDR, 32'h01);
    ctrl <= 3'h1;
    a20 <= 1'b1;
    tick(1);
    `CHK(pin_oe, 8'h81)
    `CHK(pin_out[7], 1'b1)
    a20 <= 1'b0;
    tick(1);
    `CHK(pin_out[7], 1'b0)
    op_mode <= 3'h1;
    hw_standby <= 1'b1;
    tick(6);
    `CHK(pin_oe, PA_DIR_RST_ADDR)
    hw_standby <= 1'b0;
    $display("address mode test done");
    results();
  end
endmodule
